// ===== dv/udp_register_access_cmd_test.sv
// self-checking bench for the remote register protocol interpreter
// assumes the host model; a memory responder and register master live here
`timescale 1ns/100ps
`include "udp_register_access_consts.svh"
module udp_register_access_cmd_test;
  logic        core_clk, reset, slow, rx_valid, rx_last, rx_ready, tx_valid, tx_ready;
  logic        tx_done, irq, mem_req, mem_we, mem_info, mem_rvalid, reg_wr, reg_rd, rd_d;
  logic [7:0]  rx_data, tx_data, reg_addr;
  logic [15:0] rx_dst_port, rx_src_port, reply_port, mem_addr;
  logic [2:0]  mem_space;
  logic [1:0]  mem_size;
  logic [63:0] mem_wdata, mem_rdata, rv;
  logic [31:0] reg_wdata, reg_rdata, seed, exp_reg[$];
  logic [86:0] exp_mem[$];
  logic [7:0]  exp_tx[$], bq[$];
  logic [15:0] ptr_m[0:1][0:7];
  int          mismatches, n_tests;

  udp_register_access_cmd dut_u (
    .core_clk(core_clk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_dst_port(rx_dst_port), .rx_src_port(rx_src_port),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_done(tx_done), .reply_port(reply_port), .mem_req(mem_req), .mem_we(mem_we),
    .mem_info(mem_info), .mem_space(mem_space), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  udp_register_access_host host_u (
    .core_clk(core_clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_dst_port(rx_dst_port), .rx_src_port(rx_src_port),
    .rx_ready(rx_ready), .tx_ready(tx_ready));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bad(input string m);
    mismatches++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) bad(m);
  endtask
  // only the low element bytes of write data carry meaning
  task automatic chk_mem();
    logic [86:0] e;
    logic [63:0] m;
    e = exp_mem.size() ? exp_mem.pop_front() : '1;
    m = (mem_size == 2'd3) ? '1 : (64'h1 << (8 << mem_size)) - 1;
    n_tests++;
    if ({mem_we, mem_info, mem_space, mem_size, mem_addr} !== e[86:64]
        || (mem_we && (mem_wdata & m) !== (e[63:0] & m))) bad("memory access");
  endtask
  // result watcher and memory responder
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    mem_rvalid <= (mem_req === 1'b1) && !mem_we;
    if (rd_d) chk_val(reg_rdata, exp_reg.pop_front(), "register read");
    if (tx_valid === 1'b1 && tx_ready) chk_val(tx_data, exp_tx.pop_front(), "reply");
    if (mem_req === 1'b1) begin
      chk_mem();
      if (!mem_we) begin
        rv = {rnd(), rnd()};
        mem_rdata <= rv;
        for (int k = 0; k < (1 << mem_size); k++) exp_tx.push_back(rv[8*k +: 8]);
      end
    end
  end
  // one idle cycle after each strobe keeps a signal from two assignments in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_reg.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic put16(input logic [15:0] w);
    bq.push_back(w[7:0]);
    bq.push_back(w[15:8]);
  endtask
  // builds one command and notes the accesses it must cause
  task automatic op(input logic we, ai, info, input logic [2:0] sp, input logic [1:0] sz,
                    input logic inc, input logic [6:0] cnt, input logic [15:0] a);
    logic [63:0] d;
    logic        ok;
    ok = cnt != 0 && !(info && (we || sz != 2'd1));
    put16({we, ai, info, sp, sz, inc, cnt});
    if (ai) put16(a);
    if (ai && ok) ptr_m[info][sp] = a;
    for (int i = 0; i < cnt; i++) begin
      d = {rnd(), rnd()};
      if (we) for (int k = 0; k < (1 << sz); k++) bq.push_back(d[8*k +: 8]);
      if (ok) exp_mem.push_back({we, info, sp, sz, ptr_m[info][sp], d});
      if (ok && inc) ptr_m[info][sp] += 16'(1 << sz);
    end
  endtask
  task automatic pkt();
    host_u.send(bq, `RRP_UDP_PORT);
    bq.delete();
    for (int n = 0; n <= 3000 && tx_done !== 1'b1; n++) begin
      @(negedge core_clk);
      if (n == 3000) bad("no packet end");
    end
    @(posedge core_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    bad("watchdog");
    final_report();
  end
  initial begin
    seed = 32'h0000_a105;
    reset = 1'b1;
    slow = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, rd_d, mem_rvalid} = '0;
    mem_rdata = '0;
    ptr_m = '{default: 16'h0000};
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    wr(`REG_STATUS, 32'h0000_000f);
    rd(`REG_STATUS, 32'h0000_0000);
    rd(`REG_CLEAR, 32'h0000_0000);
    rd(`REG_ENABLE, 32'h0000_0000);
    rd(`REG_DEBUG, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    // foreign port packet must move nothing
    put16(16'hc201);
    put16(16'h0000);
    put16(16'h5555);
    host_u.send(bq, 16'h0050);
    bq.delete();
    rd(`REG_STATUS, 32'h0000_0000);
    chk_val(reply_port, 16'h0000, "foreign source port");
    for (int s = 0; s < 8; s++) begin
      slow <= s[0];
      op(1, 1, 0, 3'(s), 2'(s), 1, 2, 16'(rnd()));
      op(0, 0, 0, 3'(s), 2'(s), s[2], 2, 16'h0000);
      pkt();
    end
    chk_val(reply_port, 16'h1234, "reply port");
    for (int s = 0; s < 8; s++) op(0, 0, 0, 3'(s), 2'(s), 1, 1, 16'h0000);
    op(1, 1, 0, 3'd5, 2'd0, 0, 127, 16'(rnd()));
    op(0, 1, 1, 3'd2, 2'd1, 1, 3, 16'h0000);
    pkt();
    wr(`REG_ENABLE, 32'h0000_0003);
    wr(`REG_CLEAR, 32'h0000_000f);
    op(1, 1, 1, 3'd4, 2'd1, 1, 1, 16'h0002);
    pkt();
    rd(`REG_STATUS, 32'h0000_000a);
    @(negedge core_clk);
    chk_val(irq, 1, "irq after refusal");
    @(posedge core_clk);
    wr(`REG_CLEAR, 32'h0000_000f);
    repeat (2) @(negedge core_clk);
    chk_val(irq, 0, "irq after clear");
    @(posedge core_clk);
    op(0, 1, 0, 3'd6, 2'd2, 1, 0, 16'h0abc);
    pkt();
    rd(`REG_STATUS, 32'h0000_0009);
    wr(`REG_CLEAR, 32'h0000_000f);
    op(0, 0, 0, 3'd6, 2'd2, 1, 1, 16'h0000);
    pkt();
    @(negedge core_clk);
    chk_val(irq, 0, "masked packet end");
    @(posedge core_clk);
    rd(`REG_STATUS, 32'h0000_0008);
    wr(`REG_CLEAR, 32'h0000_000f);
    // a packet cut inside write data flags truncation and moves nothing
    put16(16'hc201);
    put16(16'h0000);
    put16(16'h5555);
    pkt();
    rd(`REG_STATUS, 32'h0000_000c);
    chk_val(exp_mem.size() + exp_tx.size(), 0, "left over accesses");
    final_report();
  end
endmodule

// ===== dv/udp_register_access_host.sv
// host model: sends udp payload bytes and takes reply bytes
// assumes the interpreter's valid/ready byte stream on core_clk
`timescale 1ns/100ps
module udp_register_access_host (
  // clock and pace
  input  wire logic   core_clk,
  input  wire logic   slow,
  // payload towards the interpreter
  output logic        rx_valid,
  output logic [7:0]  rx_data,
  output logic        rx_last,
  output logic [15:0] rx_dst_port,
  output logic [15:0] rx_src_port,
  input  wire logic   rx_ready,
  // reply from the interpreter
  output logic        tx_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_dst_port = 16'h0000;
    rx_src_port = 16'h0000;
    tx_ready = 1'b0;
  end
  // a slow host drops tx_ready every other cycle
  always @(posedge core_clk) tx_ready <= slow ? !tx_ready : 1'b1;
  // each byte held until taken; released data flips so a stale byte never looks fresh
  task automatic send(input logic [7:0] b[$], input logic [15:0] port);
    for (int i = 0; i < b.size(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      rx_last <= (i == b.size() - 1);
      rx_dst_port <= port;
      rx_src_port <= 16'h1234;
      @(posedge core_clk iff rx_ready);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

// ===== pkg/udp_register_access_consts.svh
// constants for the remote register protocol command interpreter
// assumes inclusion by the testbench and the interpreter module only
`ifndef UDP_REGISTER_ACCESS_CONSTS_SVH
`define UDP_REGISTER_ACCESS_CONSTS_SVH

// udp port that carries command packets (decimal 27181)
`define RRP_UDP_PORT      16'h6a2d

// command word fields
`define CMD_WRITE_BIT     15
`define CMD_ADDR_BIT      14
`define CMD_INFO_BIT      13
`define CMD_SPACE_HI      12
`define CMD_SPACE_LO      10
`define CMD_SIZE_HI       9
`define CMD_SIZE_LO       8
`define CMD_INC_BIT       7
`define CMD_COUNT_HI      6
`define CMD_COUNT_LO      0

// element size codes
`define SIZE_8            2'h0
`define SIZE_16           2'h1
`define SIZE_32           2'h2
`define SIZE_64           2'h3

// register offsets
`define REG_STATUS        8'h00
`define REG_CLEAR         8'h04
`define REG_ENABLE        8'h08
`define REG_DEBUG         8'h0c

// status bit positions
`define ST_ZERO_COUNT     0
`define ST_BAD_INFO       1
`define ST_TRUNCATED      2
`define ST_PACKET_DONE    3

// reset values
`define RST_STATUS        4'h0
`define RST_ENABLE        4'h0
`define RST_POINTER       16'h0000

`endif

// ===== pkg/udp_register_access_pkg.sv
// types shared by the remote register protocol command interpreter
// assumes the constants header is on the include path
package udp_register_access_pkg;

  typedef enum logic [3:0] {
    S_CMD_LO = 4'b0000,
    S_CMD_HI = 4'b0001,
    S_ADR_LO = 4'b0010,
    S_ADR_HI = 4'b0011,
    S_DATA   = 4'b0100,
    S_MEM    = 4'b0101,
    S_RDWAIT = 4'b0110,
    S_SEND   = 4'b0111,
    S_STEP   = 4'b1000,
    S_SKIP   = 4'b1001
  } state_e;

  typedef struct packed {
    state_e          state;
    logic [15:0]     cmd;
    logic [15:0]     addr;
    logic [6:0]      left;
    logic [2:0]      bidx;
    logic [63:0]     data;
    logic            pkt_end;
    logic [7:0][15:0] ptr;
    logic [7:0][15:0] iptr;
    logic [3:0]      status;
    logic [3:0]      irq_en;
    logic [15:0]     reply_port;
    logic            mem_req;
    logic            tx_done;
    logic [31:0]     rdata;
    logic            irq;
  } cmd_state_s;

endpackage

// ===== rtl/udp_register_access_cmd.sv
// command interpreter for the remote register protocol carried in udp payloads
// assumes a byte stream of udp payload on core_clk and a memory port that answers reads
//
// Behaviour
// - command word is 16 bits: write, address, info, space, size, increment, count
// - direction bit one means write, zero means read
// - address bit one: next 16-bit word loads the space pointer before transfer
// - address bit zero: transfer starts at the space's current pointer
// - each space keeps its own pointer, untouched by other spaces
// - info bit zero selects the space, one selects its info area
// - 3-bit space field selects one of eight spaces
// - size code 00/01/10/11 gives 8/16/32/64-bit elements
// - increment bit advances pointer by element bytes, else pointer stays fixed
// - 7-bit count gives element number, 1 to 127
// - count of zero is an error
// - every address is a byte address whatever the element size
// - words, addresses and data travel least significant byte first
// - commands arrive on udp port 27181, replies go to the source port
// - info areas allow only 16-bit reads
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
`include "udp_register_access_consts.svh"

module udp_register_access_cmd
  import udp_register_access_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // received payload stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic [15:0] rx_dst_port,
  input  wire logic [15:0] rx_src_port,
  output logic             rx_ready,
  // reply payload stream
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic             tx_done,
  output logic [15:0]      reply_port,
  // memory space port
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_info,
  output logic [2:0]       mem_space,
  output logic [1:0]       mem_size,
  output logic [15:0]      mem_addr,
  output logic [63:0]      mem_wdata,
  input  wire logic        mem_rvalid,
  input  wire logic [63:0] mem_rdata,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);

  cmd_state_s st;
  cmd_state_s next_st;

  logic        port_ok;
  logic        take;
  logic        rx_fire;
  logic [15:0] cmdw;
  logic [2:0]  bmax;
  logic [2:0]  sp;
  logic        elem_done;
  logic        cmd_end;
  logic [15:0] next_addr;
  logic [3:0]  ev;
  logic [3:0]  clr;

  assign port_ok  = (rx_dst_port == `RRP_UDP_PORT);
  assign take     = (st.state == S_CMD_LO || st.state == S_CMD_HI || st.state == S_ADR_LO ||
                     st.state == S_ADR_HI || st.state == S_DATA || st.state == S_SKIP) &&
                    !st.pkt_end;
  // foreign ports are swallowed so they never stall the stream
  assign rx_ready = port_ok ? take : 1'b1;
  assign rx_fire  = rx_valid && port_ok && take;
  assign cmdw     = {rx_data, st.cmd[7:0]};
  assign sp       = st.cmd[`CMD_SPACE_HI:`CMD_SPACE_LO];
  assign bmax     = 3'((4'h1 << st.cmd[`CMD_SIZE_HI:`CMD_SIZE_LO]) - 4'h1);

  assign tx_valid   = (st.state == S_SEND);
  assign tx_data    = st.data[7:0];
  assign tx_done    = st.tx_done;
  assign reply_port = st.reply_port;
  assign mem_req    = st.mem_req;
  assign mem_we     = st.cmd[`CMD_WRITE_BIT];
  assign mem_info   = st.cmd[`CMD_INFO_BIT];
  assign mem_space  = sp;
  assign mem_size   = st.cmd[`CMD_SIZE_HI:`CMD_SIZE_LO];
  assign mem_addr   = st.addr;
  assign mem_wdata  = st.data;
  assign reg_rdata  = st.rdata;
  assign irq        = st.irq;

  always_comb begin
    next_st         = st;
    next_st.mem_req = 1'b0;
    next_st.tx_done = 1'b0;
    next_st.rdata   = 32'h0000_0000;
    elem_done       = 1'b0;
    cmd_end         = 1'b0;
    ev              = 4'h0;
    clr             = 4'h0;
    next_addr       = st.addr + (st.cmd[`CMD_INC_BIT] ? 16'(bmax) + 16'h0001 : 16'h0000);

    if (rx_fire) begin
      next_st.reply_port = rx_src_port;
      if (rx_last) begin
        next_st.pkt_end = 1'b1;
      end
    end

    case (st.state)
      S_CMD_LO: begin
        if (st.pkt_end) begin
          next_st.pkt_end = 1'b0;
          next_st.tx_done = 1'b1;
          ev[`ST_PACKET_DONE] = 1'b1;
        end else if (rx_fire) begin
          next_st.cmd[7:0] = rx_data;
          next_st.state = S_CMD_HI;
        end
      end
      S_CMD_HI: begin
        if (st.pkt_end) begin
          ev[`ST_TRUNCATED] = 1'b1;
          next_st.state = S_CMD_LO;
        end else if (rx_fire) begin
          next_st.cmd  = cmdw;
          next_st.left = cmdw[`CMD_COUNT_HI:`CMD_COUNT_LO];
          next_st.bidx = 3'h0;
          if (cmdw[`CMD_COUNT_HI:`CMD_COUNT_LO] == 7'h00) begin
            // stream alignment is lost after a zero count, so the packet is dropped
            ev[`ST_ZERO_COUNT] = 1'b1;
            next_st.state = S_SKIP;
          end else if (cmdw[`CMD_INFO_BIT] &&
                       (cmdw[`CMD_WRITE_BIT] || cmdw[`CMD_SIZE_HI:`CMD_SIZE_LO] != `SIZE_16)) begin
            ev[`ST_BAD_INFO] = 1'b1;
            next_st.state = S_SKIP;
          end else if (cmdw[`CMD_ADDR_BIT]) begin
            next_st.state = S_ADR_LO;
          end else begin
            next_st.addr = cmdw[`CMD_INFO_BIT] ? st.iptr[cmdw[12:10]] : st.ptr[cmdw[12:10]];
            next_st.state = cmdw[`CMD_WRITE_BIT] ? S_DATA : S_MEM;
          end
        end
      end
      S_ADR_LO: begin
        if (st.pkt_end) begin
          ev[`ST_TRUNCATED] = 1'b1;
          next_st.state = S_CMD_LO;
        end else if (rx_fire) begin
          next_st.addr[7:0] = rx_data;
          next_st.state = S_ADR_HI;
        end
      end
      S_ADR_HI: begin
        if (st.pkt_end) begin
          ev[`ST_TRUNCATED] = 1'b1;
          next_st.state = S_CMD_LO;
        end else if (rx_fire) begin
          next_st.addr[15:8] = rx_data;
          next_st.state = st.cmd[`CMD_WRITE_BIT] ? S_DATA : S_MEM;
        end
      end
      S_DATA: begin
        if (st.pkt_end) begin
          ev[`ST_TRUNCATED] = 1'b1;
          next_st.state = S_CMD_LO;
        end else if (rx_fire) begin
          next_st.data[{st.bidx, 3'b000} +: 8] = rx_data;
          if (st.bidx == bmax) begin
            next_st.bidx = 3'h0;
            next_st.state = S_MEM;
          end else begin
            next_st.bidx = st.bidx + 3'h1;
          end
        end
      end
      S_MEM: begin
        next_st.mem_req = 1'b1;
        next_st.state = st.cmd[`CMD_WRITE_BIT] ? S_STEP : S_RDWAIT;
      end
      S_RDWAIT: begin
        if (mem_rvalid) begin
          next_st.data = mem_rdata;
          next_st.state = S_SEND;
        end
      end
      S_SEND: begin
        if (tx_ready) begin
          next_st.data = {8'h00, st.data[63:8]};
          if (st.bidx == bmax) begin
            next_st.bidx = 3'h0;
            next_st.state = S_STEP;
          end else begin
            next_st.bidx = st.bidx + 3'h1;
          end
        end
      end
      S_STEP: begin
        elem_done = 1'b1;
        next_st.addr = next_addr;
        if (st.left == 7'h01) begin
          cmd_end = 1'b1;
          next_st.state = S_CMD_LO;
          if (st.cmd[`CMD_INFO_BIT]) begin
            next_st.iptr[sp] = next_addr;
          end else begin
            next_st.ptr[sp] = next_addr;
          end
        end else begin
          next_st.left = st.left - 7'h01;
          next_st.state = st.cmd[`CMD_WRITE_BIT] ? S_DATA : S_MEM;
        end
      end
      S_SKIP: begin
        if (st.pkt_end) begin
          next_st.state = S_CMD_LO;
        end
      end
      default: begin
        next_st.state = S_CMD_LO;
      end
    endcase

    if (reg_wr && reg_addr == `REG_CLEAR) begin
      clr = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == `REG_ENABLE) begin
      next_st.irq_en = reg_wdata[3:0];
    end
    // a new event beats a clear in the same cycle
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq    = |(next_st.status & next_st.irq_en);

    if (reg_rd) begin
      case (reg_addr)
        `REG_STATUS: next_st.rdata = {28'h000_0000, st.status};
        `REG_ENABLE: next_st.rdata = {28'h000_0000, st.irq_en};
        `REG_DEBUG:  next_st.rdata = {12'h000, st.state, st.cmd};
        default:     next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '{state: S_CMD_LO, status: `RST_STATUS, irq_en: `RST_ENABLE,
              ptr: {8{`RST_POINTER}}, iptr: {8{`RST_POINTER}}, default: '0};
    end else begin
      st <= next_st;
    end
  end

  a_zero_count: assert property (@(posedge core_clk) disable iff (reset)
    (st.state == S_CMD_HI && rx_fire && st.cmd[`CMD_COUNT_HI:`CMD_COUNT_LO] == 7'h00) |=>
    st.status[`ST_ZERO_COUNT])
    else $error("zero count not flagged");
  a_zero_nomove: assert property (@(posedge core_clk) disable iff (reset)
    (st.state == S_CMD_HI && rx_fire && st.cmd[`CMD_COUNT_HI:`CMD_COUNT_LO] == 7'h00) |=>
    (st.state == S_SKIP && !st.mem_req && $stable(st.ptr)))
    else $error("zero count caused a transfer");
  a_dir_bit: assert property (@(posedge core_clk) disable iff (reset)
    mem_req |-> (mem_we == (st.state == S_STEP && st.cmd[15])) || (!mem_we && st.state == S_RDWAIT))
    else $error("direction does not match command");
  a_addr_load: assert property (@(posedge core_clk) disable iff (reset)
    (st.state == S_ADR_HI && rx_fire) |=> st.addr == {$past(rx_data), $past(st.addr[7:0])})
    else $error("address word not loaded");
  a_ptr_reuse: assert property (@(posedge core_clk) disable iff (reset)
    (st.state == S_CMD_HI && rx_fire && !rx_data[6] && !rx_data[5] &&
     st.cmd[`CMD_COUNT_HI:`CMD_COUNT_LO] != 7'h00)
    |=> st.addr == $past(st.ptr[rx_data[4:2]]))
    else $error("current pointer not reused");
  a_ptr_isolate: assert property (@(posedge core_clk) disable iff (reset)
    !cmd_end |=> $stable(st.ptr) && $stable(st.iptr))
    else $error("pointer changed outside command end");
  a_space_sel: assert property (@(posedge core_clk) disable iff (reset)
    mem_req |-> mem_space == st.cmd[12:10] && mem_info == st.cmd[13])
    else $error("wrong space selected");
  a_addr_step: assert property (@(posedge core_clk) disable iff (reset)
    (elem_done && st.left != 7'h01) |=>
    st.addr == $past(st.addr) + ($past(st.cmd[7]) ? 16'(bmax) + 16'h0001 : 16'h0000))
    else $error("pointer step wrong");
  a_info_read: assert property (@(posedge core_clk) disable iff (reset)
    (mem_req && mem_info) |-> !mem_we && mem_size == `SIZE_16)
    else $error("illegal info access");
  a_port_filter: assert property (@(posedge core_clk) disable iff (reset)
    (rx_valid && !port_ok) |-> rx_ready && !rx_fire)
    else $error("foreign byte stalled or taken");
  a_byte_order: assert property (@(posedge core_clk) disable iff (reset)
    (st.state == S_RDWAIT && mem_rvalid) |=> tx_valid && tx_data == $past(mem_rdata[7:0]))
    else $error("reply not low byte first");

endmodule
